/* servo_status_flags.sv */
// Top of the servo status flag logic reported in each response frame.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
//
// Behaviour
// - Warning flag follows warning; latch setting keeps it held afterwards.
// - Torque-clamp flag is set while the torque command is limited.
// - In torque control a setting decides whether the clamp flag reports.
// - Origin-found flag sets on homing completion and stays set.
// - Origin-found flag clears when a homing command arrives.
// - Power-on sets origin-found in absolute mode, clears it otherwise.
// - Reset command reinitialises origin-found exactly like power-on.
// - Power-on after maintenance functions leaves origin-found unchanged.
// - Profile meaning: bit high while profile generation runs in PP mode.
// - Mains-loss meaning: bit high while the mains-off alarm stands.
// - Position mode: done flag uses range, output mode and hold time.
// - Velocity mode: flag high when speed matches command within range.
// - Torque mode: flag high when speed matches limit within range.
// - Gear remainder may drop positioning done while servo is off.
// - Select bit: zero gives profile meaning, one gives mains loss.
// - Armable only with main power, no alarm and communication sync.
module servo_status_flags #(
	parameter int TICK_CYCLES = servo_flag_pkg::TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire servo_flag_pkg::core_type i_core,
	input wire logic i_frame_tick,
	output servo_flag_pkg::status_type o_status
);
	localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

	typedef enum logic [2:0] {
		ORG_LOST = 3'h1,
		ORG_HOMING = 3'h2,
		ORG_SECURED = 3'h4
	} origin_type;

	servo_flag_pkg::cfg_type cfg;
	servo_flag_pkg::status_type live;
	servo_flag_pkg::status_type status_ff;
	origin_type origin_ff;
	origin_type nxt_origin;
	origin_type init_origin;
	logic [16:0] tick_cnt_ff;
	logic ms_tick;
	logic clr_warn;
	logic warn_ff;
	logic trq_ff;
	logic nxt_trq;
	logic shared_ff;
	logic nxt_shared;
	logic mains_loss_flag;
	logic armable_ff;
	logic in_position;

	// Size is not passed to the register slave or checked at all; narrower
	// transfers are treated as word writes by this slave.
	ahb_flag_regs u_regs (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hwdata(i_hwdata),
		.i_hready(i_hready),
		.i_status(live),
		.o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp),
		.o_hrdata(o_hrdata),
		.o_cfg(cfg),
		.o_clr_warn(clr_warn)
	);

	in_position_eval u_inpos (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_ms_tick(ms_tick),
		.i_cfg(cfg),
		.i_core(i_core),
		.o_in_position(in_position)
	);

	// Millisecond enable for the hold timer; the count is a parameter so
	// a simulation can shorten it.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst || tick_cnt_ff == TICK_LAST)
			tick_cnt_ff <= 17'h00000;
		else
			tick_cnt_ff <= tick_cnt_ff + 17'h00001;
	end

	assign ms_tick = tick_cnt_ff == TICK_LAST;

	// A live warning always sets the flag, so it wins over a clear.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			warn_ff <= 1'b0;
		else if (i_core.warning)
			warn_ff <= 1'b1;
		else if (!cfg.warn_latch || clr_warn)
			warn_ff <= 1'b0;
	end

	// Torque control may mask the clamp flag by configuration.
	always_comb
	begin
		nxt_trq = i_core.torque_limited;
		if (i_core.ctl_mode == servo_flag_pkg::CTL_TRQ && cfg.trq_sel)
		begin
			nxt_trq = 1'b0;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			trq_ff <= 1'b0;
		else
			trq_ff <= nxt_trq;
	end

	// An absolute encoder knows home at power-on; incremental does not.
	assign init_origin = i_core.abs_mode ? ORG_SECURED : ORG_LOST;

	// Origin tracking. Power-on and reset command reinitialise; a
	// maintenance power-on keeps the state. Completion in the same cycle
	// as a new homing command wins; only power-on or a reset command beats it.
	always_comb
	begin
		case (origin_ff)
			ORG_LOST, ORG_HOMING, ORG_SECURED:
			begin
				nxt_origin = origin_ff;
				if (i_core.power_on || i_core.reset_cmd)
					nxt_origin = init_origin;
				else if (i_core.homing_done)
					nxt_origin = ORG_SECURED;
				else if (i_core.homing_cmd)
					nxt_origin = ORG_HOMING;
			end
			default: nxt_origin = ORG_LOST;
		endcase
	end

	// The flop reset stands for control power-on with no strap known;
	// the core's power-on pulse then loads the real mode.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			origin_ff <= ORG_LOST;
		else
			origin_ff <= nxt_origin;
	end

	// Shared bit meaning is chosen by the select bit.
	assign mains_loss_flag = i_core.mains_off_alarm;
	always_comb
	begin
		if (cfg.shared_sel)
			nxt_shared = mains_loss_flag;
		else
			nxt_shared = i_core.profile_position_mode
				&& i_core.pp_generating;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			shared_ff <= 1'b0;
		else
			shared_ff <= nxt_shared;
	end

	// All three conditions are needed before the servo may arm.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			armable_ff <= 1'b0;
		else
			armable_ff <= i_core.main_power_ok && !i_core.alarm
				&& i_core.sync_ok;
	end

	// Live view of the byte; alarm and active pass straight from the core.
	always_comb
	begin
		live.servo_active = i_core.servo_active;
		live.servo_ready = armable_ff;
		live.alarm = i_core.alarm;
		live.warning = warn_ff;
		live.torque_limited = trq_ff;
		live.homing_complete = origin_ff == ORG_SECURED;
		live.shared = shared_ff;
		live.in_position = in_position;
	end

	// The frame copy stays stable for the whole response frame, which
	// costs one frame of latency but avoids a torn status byte.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			status_ff <= 8'h00;
		else if (i_frame_tick)
			status_ff <= live;
	end

	assign o_status = status_ff;

	a_warn_set: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		i_core.warning |=> live.warning)
		else $error("Warning flag missed an active warning.");

	a_warn_held: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(live.warning && cfg.warn_latch && !clr_warn) |=> live.warning)
		else $error("Latched warning flag dropped without a clear.");

	a_trq_clamp: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.torque_limited
		&& i_core.ctl_mode != servo_flag_pkg::CTL_TRQ)
		|=> live.torque_limited)
		else $error("Torque clamp flag missing while limited.");

	a_trq_mask: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.ctl_mode == servo_flag_pkg::CTL_TRQ && cfg.trq_sel)
		|=> !live.torque_limited)
		else $error("Torque clamp flag shown while masked.");

	a_origin_keep: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.homing_done && !i_core.power_on && !i_core.reset_cmd)
		|=> live.homing_complete ##1 (live.homing_complete
		|| $past(i_core.homing_cmd || i_core.power_on
		|| i_core.reset_cmd)))
		else $error("Origin flag not kept after homing completion.");

	a_origin_clear: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.homing_cmd && !i_core.homing_done && !i_core.power_on
		&& !i_core.reset_cmd) |=> !live.homing_complete)
		else $error("Origin flag not cleared by homing command.");

	a_origin_init: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.power_on || i_core.reset_cmd)
		|=> live.homing_complete == $past(i_core.abs_mode))
		else $error("Origin flag not reinitialised from the mode.");

	a_maint_keep: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.maint_power_on && !i_core.power_on && !i_core.reset_cmd
		&& !i_core.homing_cmd && !i_core.homing_done)
		|=> $stable(live.homing_complete))
		else $error("Maintenance power-on changed the origin flag.");

	a_shared_sel: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		!cfg.shared_sel |=> live.shared == $past(
		i_core.profile_position_mode && i_core.pp_generating))
		else $error("Profile meaning of shared bit is wrong.");

	a_shared_ac: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(cfg.shared_sel && i_core.mains_off_alarm) |=> live.shared)
		else $error("Mains loss not shown on the shared bit.");

	a_armable: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		live.servo_ready |-> $past(i_core.main_power_ok
		&& !i_core.alarm && i_core.sync_ok))
		else $error("Armable shown without all three conditions.");

	a_frame_copy: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		i_frame_tick |=> o_status == $past(live)
		and (!i_frame_tick [*2] |-> $stable(o_status)))
		else $error("Status byte not sampled on the frame strobe.");
endmodule

/* servo_flag_pkg.sv */
// Constants and types shared by the servo status flag logic.
package servo_flag_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_INPOS = 8'h04;
	localparam logic [7:0] OFF_SPEED = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_CTRL = 8'h10;
	// Field positions inside the registers.
	localparam int CFG_WARN_LATCH = 0;
	localparam int CFG_TRQ_SEL = 1;
	localparam int CFG_SHARED_SEL = 8;
	localparam int INP_RANGE_LSB = 0;
	localparam int INP_MODE_LSB = 16;
	localparam int INP_HOLD_LSB = 24;
	localparam int SPD_RANGE_LSB = 0;
	localparam int CTRL_CLR_WARN = 0;
	// Reset values of the configuration fields.
	localparam logic CFG_BIT_RST = 1'h0;
	localparam logic [15:0] INP_RANGE_RST = 16'h000A;
	localparam logic [1:0] INP_MODE_RST = 2'h0;
	localparam logic [7:0] INP_HOLD_RST = 8'h00;
	localparam logic [15:0] SPD_RANGE_RST = 16'h0032;
	// Timing: the hold time counts in steps of one millisecond.
	localparam int CLOCK_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_NS + CLOCK_NS - 1) / CLOCK_NS;
	// Completion output modes.
	localparam logic [1:0] INP_MODE_DEV = 2'h0;
	localparam logic [1:0] INP_MODE_IDLE = 2'h1;
	localparam logic [1:0] INP_MODE_HOLD = 2'h2;

	typedef enum logic [1:0] {
		CTL_POS = 2'h0,
		CTL_VEL = 2'h1,
		CTL_TRQ = 2'h2,
		CTL_RSVD = 2'h3
	} ctl_mode_type;

	typedef struct packed {
		logic warn_latch;
		logic trq_sel;
		logic shared_sel;
		logic [15:0] inp_range;
		logic [1:0] inp_mode;
		logic [7:0] inp_hold;
		logic [15:0] spd_range;
	} cfg_type;

	typedef struct packed {
		logic servo_active;
		logic alarm;
		logic main_power_ok;
		logic sync_ok;
		logic warning;
		logic torque_limited;
		logic profile_position_mode;
		logic pp_generating;
		logic mains_off_alarm;
		logic abs_mode;
		logic homing_done;
		logic homing_cmd;
		logic reset_cmd;
		logic power_on;
		logic maint_power_on;
		ctl_mode_type ctl_mode;
		logic [15:0] pos_dev;
		logic signed [15:0] act_speed;
		logic signed [15:0] cmd_speed;
		logic signed [15:0] speed_limit;
	} core_type;

	typedef struct packed {
		logic servo_active;
		logic servo_ready;
		logic alarm;
		logic warning;
		logic torque_limited;
		logic homing_complete;
		logic shared;
		logic in_position;
	} status_type;
endpackage

/* in_position_eval.sv */
// Target-reached evaluation: positioning done or speed match by mode.
`timescale 1ns/1ps
module in_position_eval (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_ms_tick,
	input wire servo_flag_pkg::cfg_type i_cfg,
	input wire servo_flag_pkg::core_type i_core,
	output logic o_in_position
);
	logic pos_cond;
	logic spd_ok;
	logic nxt_in_position;
	logic signed [15:0] spd_target;
	logic signed [16:0] spd_diff;
	logic [16:0] spd_mag;
	logic [7:0] hold_cnt_ff;
	logic in_pos_ff;

	// Speed target is the command in velocity mode, the limit in torque.
	always_comb
	begin
		spd_target = i_core.cmd_speed;
		if (i_core.ctl_mode == servo_flag_pkg::CTL_TRQ)
		begin
			spd_target = i_core.speed_limit;
		end
		spd_diff = {i_core.act_speed[15], i_core.act_speed}
			- {spd_target[15], spd_target};
		spd_mag = spd_diff[16] ? 17'(-spd_diff) : 17'(spd_diff);
		spd_ok = spd_mag <= {1'b0, i_cfg.spd_range};
	end

	// A gear remainder can keep the deviation off zero at servo-off,
	// so the flag may drop there; this is intended behaviour.
	always_comb
	begin
		pos_cond = i_core.pos_dev <= i_cfg.inp_range;
		if (i_cfg.inp_mode != servo_flag_pkg::INP_MODE_DEV)
		begin
			pos_cond = pos_cond && !i_core.pp_generating;
		end
	end

	// Hold counter reloads while the condition stands, then counts ms.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			hold_cnt_ff <= 8'h00;
		else if (pos_cond)
			hold_cnt_ff <= i_cfg.inp_hold;
		else if (i_ms_tick && hold_cnt_ff != 8'h00)
			hold_cnt_ff <= hold_cnt_ff - 8'h01;
	end

	// Mode selects which condition drives the flag.
	always_comb
	begin
		case (i_core.ctl_mode)
			servo_flag_pkg::CTL_POS:
				nxt_in_position = pos_cond
					|| (i_cfg.inp_mode == servo_flag_pkg::INP_MODE_HOLD
					&& hold_cnt_ff != 8'h00);
			servo_flag_pkg::CTL_VEL: nxt_in_position = spd_ok;
			servo_flag_pkg::CTL_TRQ: nxt_in_position = spd_ok;
			default: nxt_in_position = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			in_pos_ff <= 1'b0;
		else
			in_pos_ff <= nxt_in_position;
	end

	assign o_in_position = in_pos_ff;

	a_inp_hold: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		($fell(pos_cond) && i_core.ctl_mode == servo_flag_pkg::CTL_POS
		&& $stable(i_core.ctl_mode)
		&& i_cfg.inp_mode == servo_flag_pkg::INP_MODE_HOLD
		&& i_cfg.inp_hold != 8'h00) |=> o_in_position)
		else $error("Positioning done dropped inside its hold time.");

	a_speed_match: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.ctl_mode == servo_flag_pkg::CTL_VEL
		&& i_core.act_speed == i_core.cmd_speed) |=> o_in_position)
		else $error("Speed match not reported at equal speeds.");

	a_limit_match: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_core.ctl_mode == servo_flag_pkg::CTL_TRQ
		&& i_core.act_speed == i_core.speed_limit) |=> o_in_position)
		else $error("Speed limit match not reported in torque mode.");
endmodule

/* ahb_flag_regs.sv */
// AHB-Lite register slave holding configuration and status readback.
`timescale 1ns/1ps
module ahb_flag_regs (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire servo_flag_pkg::status_type i_status,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	output servo_flag_pkg::cfg_type o_cfg,
	output logic o_clr_warn
);
	logic accept;
	logic wr_ff;
	logic rd_ff;
	logic rd_done_ff;
	logic [7:0] addr_ff;
	logic [31:0] rd_val;
	logic [31:0] hrdata_ff;
	servo_flag_pkg::cfg_type cfg_ff;

	assign accept = i_hsel && i_htrans[1] && i_hready;

	// Address phase capture; reads hold one wait state to load data.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			addr_ff <= 8'h00;
		end
		else if (o_hreadyout)
		begin
			wr_ff <= accept && i_hwrite;
			rd_ff <= accept && !i_hwrite;
			addr_ff <= {i_haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			rd_done_ff <= 1'b0;
		else
			rd_done_ff <= rd_ff && !rd_done_ff;
	end

	assign o_hreadyout = !(rd_ff && !rd_done_ff);
	assign o_hresp = 1'b0;

	// Unmapped addresses read as zero and ignore writes.
	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (addr_ff)
			servo_flag_pkg::OFF_CFG:
			begin
				rd_val[servo_flag_pkg::CFG_WARN_LATCH] = cfg_ff.warn_latch;
				rd_val[servo_flag_pkg::CFG_TRQ_SEL] = cfg_ff.trq_sel;
				rd_val[servo_flag_pkg::CFG_SHARED_SEL] = cfg_ff.shared_sel;
			end
			servo_flag_pkg::OFF_INPOS:
			begin
				rd_val[servo_flag_pkg::INP_RANGE_LSB +: 16] = cfg_ff.inp_range;
				rd_val[servo_flag_pkg::INP_MODE_LSB +: 2] = cfg_ff.inp_mode;
				rd_val[servo_flag_pkg::INP_HOLD_LSB +: 8] = cfg_ff.inp_hold;
			end
			servo_flag_pkg::OFF_SPEED:
				rd_val[servo_flag_pkg::SPD_RANGE_LSB +: 16] = cfg_ff.spd_range;
			servo_flag_pkg::OFF_STATUS: rd_val[7:0] = i_status;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			hrdata_ff <= 32'h0000_0000;
		else if (rd_ff && !rd_done_ff)
			hrdata_ff <= rd_val;
	end

	// Configuration writes land at the end of the data phase.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			cfg_ff.warn_latch <= servo_flag_pkg::CFG_BIT_RST;
			cfg_ff.trq_sel <= servo_flag_pkg::CFG_BIT_RST;
			cfg_ff.shared_sel <= servo_flag_pkg::CFG_BIT_RST;
			cfg_ff.inp_range <= servo_flag_pkg::INP_RANGE_RST;
			cfg_ff.inp_mode <= servo_flag_pkg::INP_MODE_RST;
			cfg_ff.inp_hold <= servo_flag_pkg::INP_HOLD_RST;
			cfg_ff.spd_range <= servo_flag_pkg::SPD_RANGE_RST;
		end
		else if (wr_ff && addr_ff == servo_flag_pkg::OFF_CFG)
		begin
			cfg_ff.warn_latch <= i_hwdata[servo_flag_pkg::CFG_WARN_LATCH];
			cfg_ff.trq_sel <= i_hwdata[servo_flag_pkg::CFG_TRQ_SEL];
			cfg_ff.shared_sel <= i_hwdata[servo_flag_pkg::CFG_SHARED_SEL];
		end
		else if (wr_ff && addr_ff == servo_flag_pkg::OFF_INPOS)
		begin
			cfg_ff.inp_range <= i_hwdata[servo_flag_pkg::INP_RANGE_LSB +: 16];
			cfg_ff.inp_mode <= i_hwdata[servo_flag_pkg::INP_MODE_LSB +: 2];
			cfg_ff.inp_hold <= i_hwdata[servo_flag_pkg::INP_HOLD_LSB +: 8];
		end
		else if (wr_ff && addr_ff == servo_flag_pkg::OFF_SPEED)
			cfg_ff.spd_range <= i_hwdata[servo_flag_pkg::SPD_RANGE_LSB +: 16];
	end

	assign o_clr_warn = wr_ff && addr_ff == servo_flag_pkg::OFF_CTRL
		&& i_hwdata[servo_flag_pkg::CTRL_CLR_WARN];
	assign o_cfg = cfg_ff;
	assign o_hrdata = hrdata_ff;
endmodule

/* host_frame_model.sv */
// Host-side model: issues response frame ticks and captures the status byte.
`timescale 1ns/1ps
module host_frame_model #(
	parameter int FRAME_CYCLES = 8
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire servo_flag_pkg::status_type i_status,
	output logic o_frame_tick,
	output servo_flag_pkg::status_type o_seen,
	output logic [15:0] o_frames
);
	logic [7:0] count_ff;
	logic tick_q_ff;
	// The host frames at a fixed communication cycle, one tick per frame.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			count_ff <= 8'h00;
			o_frame_tick <= 1'b0;
		end
		else
		begin
			o_frame_tick <= (count_ff == 8'(FRAME_CYCLES - 1));
			if (count_ff == 8'(FRAME_CYCLES - 1))
				count_ff <= 8'h00;
			else
				count_ff <= count_ff + 8'h01;
		end
	end
	// The byte is taken one cycle after the tick, once the frame copy settled.
	always_ff @(posedge i_clock)
	begin
		tick_q_ff <= o_frame_tick & ~i_sys_rst;
		if (i_sys_rst)
			o_frames <= 16'h0000;
		else if (tick_q_ff)
		begin
			o_seen <= i_status;
			o_frames <= o_frames + 16'h0001;
		end
	end
endmodule

/* tb_top.sv */
// Self-checking bench for the servo status flag logic.
`timescale 1ns/1ps
module tb_top;
	logic i_clock, i_sys_rst, i_hsel, i_hwrite, i_hready, frame_tick, tick_q;
	logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize;
	logic o_hreadyout, o_hresp;
	logic [15:0] frames;
	servo_flag_pkg::core_type core;
	servo_flag_pkg::status_type o_status, seen, st_q;
	int num_errors, n_tests, a, b;
	int ks[8] = '{0, 2, 4, 3, 4, 1, 1, 0};
	assign i_hready = o_hreadyout;
	servo_status_flags #(.TICK_CYCLES(10)) i_dut (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hsize(i_hsize),
		.i_hwdata(i_hwdata),
		.i_hready(i_hready),
		.o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp),
		.o_hrdata(o_hrdata),
		.i_core(core),
		.i_frame_tick(frame_tick),
		.o_status(o_status)
	);
	host_frame_model #(.FRAME_CYCLES(8)) i_host (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_status(o_status),
		.o_frame_tick(frame_tick),
		.o_seen(seen),
		.o_frames(frames)
	);
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// The status byte may only move right after a frame tick.
	always @(posedge i_clock)
	begin
		if (!i_sys_rst && !tick_q && o_status !== st_q)
			chk("status between frames", 32'(st_q), 32'(o_status));
		st_q <= o_status;
		tick_q <= frame_tick;
	end
	task stop_test;
		$display("errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Bounded wait for hready, sampled at the edge just passed.
	task wait_ready;
		int n;
		n = 0;
		while (o_hreadyout !== 1'b1)
		begin
			@(posedge i_clock);
			n++;
			if (n > 20)
			begin
				num_errors++;
				stop_test();
			end
		end
	endtask
	// One single word transfer; read data lands in rd.
	task bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
		i_hsel <= 1'b1;
		i_haddr <= {24'h000000, adr};
		i_htrans <= 2'h2;
		i_hwrite <= wr;
		@(posedge i_clock);
		wait_ready();
		i_htrans <= 2'h0;
		i_hsel <= 1'b0;
		i_hwdata <= wd;
		@(posedge i_clock);
		wait_ready();
		rd = o_hrdata;
		chk("hresp", 32'h0, 32'(o_hresp));
	endtask
	// Two captures so that the second certainly saw the settled inputs.
	task frame;
		logic [15:0] f;
		int n;
		f = frames;
		n = 0;
		while (frames !== f + 16'h0002)
		begin
			@(posedge i_clock);
			n++;
			if (n > 40)
			begin
				num_errors++;
				stop_test();
			end
		end
	endtask
	task pulse(input int k);
		case (k)
			0: core.power_on <= 1'b1;
			1: core.reset_cmd <= 1'b1;
			2: core.homing_cmd <= 1'b1;
			3: core.homing_done <= 1'b1;
			default: core.maint_power_on <= 1'b1;
		endcase
		@(posedge i_clock);
		core.power_on <= 1'b0;
		core.reset_cmd <= 1'b0;
		core.homing_cmd <= 1'b0;
		core.homing_done <= 1'b0;
		core.maint_power_on <= 1'b0;
		@(posedge i_clock);
	endtask
	function automatic logic near(input int x, input int y, input int r);
		return (x - y <= r) && (y - x <= r);
	endfunction
	initial
	begin
		i_sys_rst = 1'b1;
		i_hsel = 1'b0;
		i_haddr = 32'h0;
		i_htrans = 2'h0;
		i_hwrite = 1'b0;
		i_hsize = 3'h2;
		i_hwdata = 32'h0;
		core = '0;
		void'($urandom(28090));
		repeat (12) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		@(posedge i_clock);
		chk("status after reset", 32'h0, 32'(o_status));
		bus(1'b0, 8'h04, 32'h0);
		chk("inpos reset", 32'h0000000A, rd);
		bus(1'b0, 8'h08, 32'h0);
		chk("speed reset", 32'h00000032, rd);
		bus(1'b1, 8'h20, 32'hFFFFFFFF);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, 8'h00, 32'h00000103);
		bus(1'b0, 8'h00, 32'h0);
		chk("cfg", 32'h00000103, rd);
		$display("test registers done");
		// Origin flag across power-on, reset, homing and maintenance events.
		for (int i = 0; i < 8; i++)
		begin
			core.abs_mode <= 1'(8'h5F >> i);
			pulse(ks[i]);
			frame();
			chk("homing", 32'(8'h59 >> i) & 32'h1, 32'(seen.homing_complete));
		end
		$display("test origin done");
		core.warning <= 1'b1;
		frame();
		chk("warning", 32'h1, 32'(seen.warning));
		core.warning <= 1'b0;
		frame();
		chk("warning latched", 32'h1, 32'(seen.warning));
		bus(1'b1, 8'h10, 32'h1);
		frame();
		chk("warning cleared", 32'h0, 32'(seen.warning));
		core.torque_limited <= 1'b1;
		core.ctl_mode <= servo_flag_pkg::CTL_TRQ;
		frame();
		chk("clamp masked", 32'h0, 32'(seen.torque_limited));
		core.mains_off_alarm <= 1'b1;
		frame();
		chk("mains loss", 32'h1, 32'(seen.shared));
		bus(1'b1, 8'h00, 32'h0);
		core.warning <= 1'b1;
		frame();
		chk("clamp", 32'h1, 32'(seen.torque_limited));
		chk("shared profile", 32'h0, 32'(seen.shared));
		core.warning <= 1'b0;
		core.profile_position_mode <= 1'b1;
		core.pp_generating <= 1'b1;
		frame();
		chk("warning follows", 32'h0, 32'(seen.warning));
		chk("generating", 32'h1, 32'(seen.shared));
		core.pp_generating <= 1'b0;
		frame();
		chk("generated", 32'h0, 32'(seen.shared));
		$display("test flags done");
		for (int i = 0; i < 8; i++)
		begin
			core.main_power_ok <= i[0];
			core.servo_active <= i[0];
			core.alarm <= i[1];
			core.sync_ok <= i[2];
			frame();
			chk("armable", 32'(i == 5), 32'(seen.servo_ready));
			chk("alarm", 32'(i[1]), 32'(seen.alarm));
			chk("active", 32'(i[0]), 32'(seen.servo_active));
		end
		$display("test armable done");
		// Speed match in velocity then torque control, with range edges.
		for (int i = 0; i < 16; i++)
		begin
			a = int'($urandom_range(200)) - 100;
			b = a + int'($urandom_range(120)) - 60;
			if (i % 8 == 0)
				b = a + 50;
			if (i % 8 == 1)
				b = a - 51;
			core.ctl_mode <= (i < 8) ? servo_flag_pkg::CTL_VEL : servo_flag_pkg::CTL_TRQ;
			core.act_speed <= 16'(a);
			core.cmd_speed <= 16'((i < 8) ? b : a + 500);
			core.speed_limit <= 16'((i < 8) ? a + 500 : b);
			frame();
			chk("speed match", 32'(near(a, b, 50)), 32'(seen.in_position));
		end
		$display("test speed done");
		core.ctl_mode <= servo_flag_pkg::CTL_POS;
		core.pos_dev <= 16'h000A;
		frame();
		chk("in range", 32'h1, 32'(seen.in_position));
		core.pos_dev <= 16'h000B;
		frame();
		chk("out of range", 32'h0, 32'(seen.in_position));
		bus(1'b1, 8'h04, 32'h0001000A);
		core.pos_dev <= 16'h0003;
		core.pp_generating <= 1'b1;
		frame();
		chk("done while generating", 32'h0, 32'(seen.in_position));
		core.pp_generating <= 1'b0;
		bus(1'b1, 8'h04, 32'h0202000A);
		frame();
		chk("done", 32'h1, 32'(seen.in_position));
		core.pos_dev <= 16'h00C8;
		bus(1'b0, 8'h0C, 32'h0);
		chk("held", 32'h1, rd & 32'h1);
		repeat (40) @(posedge i_clock);
		bus(1'b0, 8'h0C, 32'h0);
		chk("hold expired", 32'h0, rd & 32'h1);
		// A mode with no meaning never reports target reached.
		core.pos_dev <= 16'h0000;
		core.ctl_mode <= servo_flag_pkg::CTL_RSVD;
		frame();
		chk("no mode", 32'h0, 32'(seen.in_position));
		$display("test position done");
		stop_test();
	end
endmodule
